// ==== logic/cssc_map.svh ====
// register offsets, field positions, fuse codes and timing constants of the clock/sleep block
`ifndef CSSC_MAP_SVH
`define CSSC_MAP_SVH
// ----------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define CSSC_ADDR_PWR_CTL 4'h0
`define CSSC_ADDR_TRIM 4'h4
`define CSSC_ADDR_STATUS 4'h8
`define CSSC_RESP_OKAY 2'h0
`define CSSC_RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// power control register fields
// ----------------------------------------------------------------
`define CSSC_PC_SM2 7
`define CSSC_PC_SE 6
`define CSSC_PC_SM1 5
`define CSSC_PC_SM0 4
`define CSSC_PC_RESET 8'h00
// ----------------------------------------------------------------
// factory trim location and fuse codes
// ----------------------------------------------------------------
`define CSSC_SIG_ROW_TRIM_ADDR 8'h00
`define CSSC_CK_EXT 4'h0
`define CSSC_CK_RC_1M 4'h1
`define CSSC_CK_RC_8M 4'h4
`define CSSC_CK_XTAL_FIRST 4'hA
`define CSSC_SUT_NONE 2'h0
`define CSSC_SUT_SHORT 2'h1
`define CSSC_SUT_LONG 2'h2
`define CSSC_FUSE_CK_SHIPPED 4'h1
`define CSSC_FUSE_SUT_SHIPPED 2'h2
// ----------------------------------------------------------------
// trim range in percent of nominal
// ----------------------------------------------------------------
`define CSSC_PCT_MIN_LO 50
`define CSSC_PCT_MAX_LO 100
`define CSSC_TRIM_FULL 255
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSSC_CLK_PERIOD_NS 10
`define CSSC_T_RST_SHORT_US 4100
`define CSSC_T_RST_LONG_US 65000
`define CSSC_WAKE_CK 6
`define CSSC_WAKE_STALL 4
`endif

// ==== logic/cssc_pkg.sv ====
// types shared by the clock source and sleep control block
`default_nettype none
package cssc_pkg;
	// control sequencer, gray along reset -> run -> sleep -> wake
	typedef enum logic [1:0] {
		CSSC_ST_RST = 2'h0,
		CSSC_ST_RUN = 2'h1,
		CSSC_ST_SLEEP = 2'h3,
		CSSC_ST_WAKE = 2'h2
	} cssc_state_t;
	// power state select encoding
	typedef enum logic [2:0] {
		CSSC_M_IDLE = 3'h0,
		CSSC_M_ADCNR = 3'h1,
		CSSC_M_PDOWN = 3'h2,
		CSSC_M_PSAVE = 3'h3,
		CSSC_M_RSV4 = 3'h4,
		CSSC_M_RSV5 = 3'h5,
		CSSC_M_STBY = 3'h6,
		CSSC_M_XSTBY = 3'h7
	} cssc_mode_t;
	// whole state of the block
	typedef struct packed {
		cssc_state_t state;
		cssc_mode_t mode;
		logic [22:0] cnt;
		logic [7:0] pwr_ctl;
		logic [7:0] trim;
		logic [3:0] ck_fuse;
		logic [1:0] sut_fuse;
		logic opt_fuse;
		logic adc_start;
		logic resume;
		logic [3:0] awaddr;
		logic aw_ok;
		logic [7:0] wdata;
		logic wstrb0;
		logic w_ok;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cssc_regs_t;
endpackage : cssc_pkg
`default_nettype wire

// ==== logic/cssc_top.sv ====
// clock source selection, rc trim and sleep sequencing with an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "cssc_map.svh"

module cssc_top import cssc_pkg::*; #(
	parameter int unsigned RST_SHORT_CYC = `CSSC_T_RST_SHORT_US * 1000 / `CSSC_CLK_PERIOD_NS,
	parameter int unsigned RST_LONG_CYC = `CSSC_T_RST_LONG_US * 1000 / `CSSC_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address / data / response
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address / data
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// fuse array and signature row, static while running
	input wire logic fuses_programmed,
	input wire logic [3:0] clock_source_fuses,
	input wire logic [1:0] startup_delay_fuses,
	input wire logic oscillator_option_fuse,
	output logic [7:0] sig_row_addr,
	input wire logic [7:0] sig_row_hi_byte,
	// cpu side
	input wire logic sleep_instr,
	input wire logic adc_enabled,
	input wire logic wake_ext_irq,
	input wire logic wake_async_irq,
	input wire logic wake_adc_irq,
	input wire logic wake_periph_irq,
	output logic cpu_resume,
	output logic adc_autostart,
	// oscillator control
	output logic rc_osc_en,
	output logic [1:0] rc_nominal_sel,
	output logic [7:0] rc_trim_value,
	output logic [7:0] rc_min_pct,
	output logic [7:0] rc_max_pct,
	output logic ext_clk_sel,
	output logic main_osc_en,
	output logic wdt_osc_en,
	// clock domain gates
	output logic clk_cpu_en,
	output logic clk_flash_en,
	output logic clk_io_en,
	output logic clk_adc_en,
	output logic clk_asy_en,
	output logic [3:0] int_sense_ctl
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cssc_regs_t q; // registered state
	cssc_regs_t d; // next state
	logic [3:0] ck_eff; // fuse code in effect at reset
	logic [1:0] sut_eff; // start-up code in effect at reset
	logic xtal_src; // crystal or resonator is the source
	logic mode_ok; // selected power state may be entered
	logic wake_hit; // wake source allowed in current mode
	logic osc_stopped; // oscillator is off in current mode
	logic do_wr; // both write halves are held
	logic [31:0] rd_word; // word for the read address
	logic [1:0] rd_resp; // answer for the read address
	cssc_mode_t sel_mode; // mode field of the control register

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	// blank fuse array falls back to the shipped settings
	assign ck_eff = fuses_programmed ? clock_source_fuses : `CSSC_FUSE_CK_SHIPPED;
	assign sut_eff = fuses_programmed ? startup_delay_fuses : `CSSC_FUSE_SUT_SHIPPED;
	assign xtal_src = (q.ck_fuse >= `CSSC_CK_XTAL_FIRST);
	// select bits are scattered: 7 is msb, then 5 and 4
	assign sel_mode = cssc_mode_t'({q.pwr_ctl[`CSSC_PC_SM2], q.pwr_ctl[`CSSC_PC_SM1],
		q.pwr_ctl[`CSSC_PC_SM0]});

	// which modes may be entered; reserved codes act as no sleep
	always_comb begin
		unique case (sel_mode)
			CSSC_M_RSV4, CSSC_M_RSV5: mode_ok = 1'b0;
			CSSC_M_STBY, CSSC_M_XSTBY: mode_ok = xtal_src;
			default: mode_ok = 1'b1;
		endcase
	end

	// wake sources per mode; idle takes everything
	always_comb begin
		unique case (q.mode)
			CSSC_M_IDLE: wake_hit = wake_ext_irq | wake_periph_irq | wake_async_irq |
				wake_adc_irq;
			CSSC_M_ADCNR: wake_hit = wake_ext_irq | wake_async_irq | wake_adc_irq;
			CSSC_M_PSAVE, CSSC_M_XSTBY: wake_hit = wake_ext_irq | wake_async_irq;
			default: wake_hit = wake_ext_irq;
		endcase
	end

	// only power-down and power-save stop the oscillator
	assign osc_stopped = (q.mode == CSSC_M_PDOWN) || (q.mode == CSSC_M_PSAVE);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = `CSSC_RESP_OKAY;
		unique case (s_axi_araddr)
			`CSSC_ADDR_PWR_CTL: rd_word = {24'h00_0000, q.pwr_ctl};
			`CSSC_ADDR_TRIM: rd_word = {24'h00_0000, q.trim};
			`CSSC_ADDR_STATUS: rd_word = {16'h0000, 2'h0, q.sut_fuse, q.ck_fuse,
				q.opt_fuse, main_osc_en, clk_asy_en, clk_adc_en, clk_io_en, clk_cpu_en,
				q.state};
			default: rd_resp = `CSSC_RESP_SLVERR; // unmapped word reads zero
		endcase
	end

	assign do_wr = q.aw_ok && q.w_ok && !q.bvalid;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.adc_start = 1'b0;
		d.resume = 1'b0;
		// write address and data are taken in either order
		if (!q.aw_ok && !q.bvalid && s_axi_awvalid) begin
			d.awaddr = s_axi_awaddr;
			d.aw_ok = 1'b1;
		end
		if (!q.w_ok && !q.bvalid && s_axi_wvalid) begin
			d.wdata = s_axi_wdata[7:0];
			d.wstrb0 = s_axi_wstrb[0];
			d.w_ok = 1'b1;
		end
		if (do_wr) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `CSSC_RESP_OKAY;
			unique case (q.awaddr)
				`CSSC_ADDR_PWR_CTL: begin
					if (q.wstrb0) begin
						d.pwr_ctl = q.wdata;
					end
				end
				`CSSC_ADDR_TRIM: begin
					if (q.wstrb0) begin
						d.trim = q.wdata;
					end
				end
				`CSSC_ADDR_STATUS: ; // read only, write dropped
				default: d.bresp = `CSSC_RESP_SLVERR;
			endcase
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		// read channel, one outstanding
		if (!q.rvalid && s_axi_arvalid) begin
			d.rvalid = 1'b1;
			d.rdata = rd_word;
			d.rresp = rd_resp;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		// sleep sequencer
		unique case (q.state)
			CSSC_ST_RST: begin
				// reset time-out counts down in aclk cycles
				if (q.cnt == 23'h00_0000) begin
					d.state = CSSC_ST_RUN;
				end else begin
					d.cnt = q.cnt - 23'h00_0001;
				end
			end
			CSSC_ST_RUN: begin
				// the instruction does nothing unless enable is set
				if (sleep_instr && q.pwr_ctl[`CSSC_PC_SE] && mode_ok) begin
					d.state = CSSC_ST_SLEEP;
					d.mode = sel_mode;
					d.adc_start = adc_enabled && ((sel_mode == CSSC_M_IDLE) ||
						(sel_mode == CSSC_M_ADCNR));
				end
			end
			CSSC_ST_SLEEP: begin
				// start-up only where the oscillator was stopped
				if (wake_hit) begin
					d.state = CSSC_ST_WAKE;
					d.cnt = osc_stopped ? 23'(`CSSC_WAKE_CK + `CSSC_WAKE_STALL - 1) :
						23'(`CSSC_WAKE_STALL - 1);
				end
			end
			CSSC_ST_WAKE: begin
				if (q.cnt == 23'h00_0000) begin
					d.state = CSSC_ST_RUN;
					d.resume = 1'b1;
				end else begin
					d.cnt = q.cnt - 23'h00_0001;
				end
			end
		endcase
		// synchronous reset: also the way out of any sleep mode
		if (!aresetn) begin
			d = '0;
			d.state = CSSC_ST_RST;
			d.mode = CSSC_M_IDLE;
			d.pwr_ctl = `CSSC_PC_RESET;
			d.trim = sig_row_hi_byte;
			d.ck_fuse = ck_eff;
			d.sut_fuse = sut_eff;
			d.opt_fuse = oscillator_option_fuse;
			// reserved code 11 adds no reset delay
			unique case (sut_eff)
				`CSSC_SUT_SHORT: d.cnt = 23'(RST_SHORT_CYC);
				`CSSC_SUT_LONG: d.cnt = 23'(RST_LONG_CYC);
				default: d.cnt = 23'h00_0000;
			endcase
		end
	end

	// one register for the whole state
	always_ff @(posedge aclk) begin
		q <= d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !q.aw_ok && !q.bvalid;
	assign s_axi_wready = !q.w_ok && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign sig_row_addr = `CSSC_SIG_ROW_TRIM_ADDR;
	assign cpu_resume = q.resume;
	assign adc_autostart = q.adc_start;
	assign int_sense_ctl = q.pwr_ctl[3:0];
	// register file and memories are never reset or written here
	assign clk_flash_en = clk_cpu_en;

	// rc oscillator: codes 1..4 map to 1, 2, 4 and 8 MHz
	assign rc_osc_en = (q.ck_fuse >= `CSSC_CK_RC_1M) && (q.ck_fuse <= `CSSC_CK_RC_8M) &&
		main_osc_en;
	assign rc_nominal_sel = 2'(q.ck_fuse - `CSSC_CK_RC_1M);
	assign ext_clk_sel = (q.ck_fuse == `CSSC_CK_EXT);
	assign rc_trim_value = q.trim;
	// watchdog clock is independent of the chip clock choice
	assign wdt_osc_en = 1'b1;

	// trim range is linear in the trim value, so monotone by design
	assign rc_min_pct = 8'(`CSSC_PCT_MIN_LO + (32'(q.trim) * `CSSC_PCT_MIN_LO) /
		`CSSC_TRIM_FULL);
	assign rc_max_pct = 8'(`CSSC_PCT_MAX_LO + (32'(q.trim) * `CSSC_PCT_MAX_LO) /
		`CSSC_TRIM_FULL);

	// clock gates per power state
	always_comb begin
		clk_cpu_en = (q.state == CSSC_ST_RUN);
		clk_io_en = 1'b1;
		clk_adc_en = 1'b1;
		clk_asy_en = 1'b1;
		main_osc_en = 1'b1;
		if (q.state == CSSC_ST_SLEEP) begin
			unique case (q.mode)
				CSSC_M_IDLE: ;
				CSSC_M_ADCNR: clk_io_en = 1'b0;
				CSSC_M_PDOWN: begin
					{clk_io_en, clk_adc_en, clk_asy_en, main_osc_en} = 4'h0;
				end
				CSSC_M_PSAVE: {clk_io_en, clk_adc_en, main_osc_en} = 3'h0;
				CSSC_M_STBY: {clk_io_en, clk_adc_en, clk_asy_en} = 3'h0;
				default: {clk_io_en, clk_adc_en} = 2'h0; // extended standby
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sleep_needs_enable_a: assert property ((q.state == CSSC_ST_RUN &&
		sleep_instr && !q.pwr_ctl[`CSSC_PC_SE]) |=> q.state == CSSC_ST_RUN)
		else $error("slept without enable");
	sleep_enter_a: assert property ((q.state == CSSC_ST_RUN && sleep_instr &&
		q.pwr_ctl[`CSSC_PC_SE] && mode_ok) |=> (q.state == CSSC_ST_SLEEP && !clk_cpu_en))
		else $error("sleep not entered");
	reserved_mode_a: assert property ((sleep_instr && (sel_mode == CSSC_M_RSV4 ||
		sel_mode == CSSC_M_RSV5)) |=> q.state != CSSC_ST_SLEEP) else $error("reserved slept");
	standby_xtal_a: assert property ((q.state == CSSC_ST_SLEEP &&
		(q.mode == CSSC_M_STBY || q.mode == CSSC_M_XSTBY)) |-> xtal_src)
		else $error("standby without crystal");
	idle_gates_a: assert property ((q.state == CSSC_ST_SLEEP &&
		q.mode == CSSC_M_IDLE) |-> (!clk_cpu_en && !clk_flash_en && clk_io_en && clk_adc_en &&
		main_osc_en)) else $error("idle gating wrong");
	pdown_gates_a: assert property ((q.state == CSSC_ST_SLEEP &&
		q.mode == CSSC_M_PDOWN) |-> !(main_osc_en || clk_io_en || clk_adc_en || clk_asy_en))
		else $error("pdown clock on");
	// power-save keeps only the asynchronous domain alive
	psave_gates_a: assert property ((q.state == CSSC_ST_SLEEP &&
		q.mode == CSSC_M_PSAVE) |-> (clk_asy_en && !(main_osc_en || clk_io_en || clk_adc_en)))
		else $error("psave gating wrong");
	// ten quiet cycles split as eight plus two, long repetitions are costly to unroll
	wake_pdown_a: assert property ((q.state == CSSC_ST_SLEEP &&
		q.mode == CSSC_M_PDOWN && wake_ext_irq) |=> (!cpu_resume)[*8] ##1 (!cpu_resume)[*2]
		##1 cpu_resume) else $error("pdown wake time");
	wake_idle_a: assert property ((q.state == CSSC_ST_SLEEP &&
		q.mode == CSSC_M_IDLE && wake_periph_irq) |=> (!clk_cpu_en)[*4] ##1 clk_cpu_en)
		else $error("idle wake time");
	wake_stby_a: assert property ((q.state == CSSC_ST_SLEEP &&
		q.mode == CSSC_M_STBY && wake_ext_irq) |=> (!cpu_resume)[*4] ##1 cpu_resume)
		else $error("standby wake time");
	adc_start_a: assert property ((q.state == CSSC_ST_RUN && sleep_instr &&
		q.pwr_ctl[`CSSC_PC_SE] && sel_mode == CSSC_M_IDLE && adc_enabled) |=> adc_autostart)
		else $error("adc not started");
	trim_reset_a: assert property ($rose(aresetn) |-> (rc_trim_value ==
		$past(sig_row_hi_byte) && q.pwr_ctl == `CSSC_PC_RESET)) else $error("reset load wrong");
	reset_wake_a: assert property ($rose(aresetn) |-> (q.state == CSSC_ST_RST &&
		!clk_cpu_en)) else $error("reset did not restart");
	trim_mono_a: assert property ((q.trim > $past(q.trim)) |->
		(rc_max_pct >= $past(rc_max_pct))) else $error("trim not monotone");

	idle_round_c: cover property (q.state == CSSC_ST_SLEEP && q.mode == CSSC_M_IDLE ##[1:20]
		cpu_resume);
	pdown_round_c: cover property (q.state == CSSC_ST_SLEEP && q.mode == CSSC_M_PDOWN ##[1:20]
		cpu_resume);
	trim_write_c: cover property (do_wr && q.awaddr == `CSSC_ADDR_TRIM);
	reset_done_c: cover property (q.state == CSSC_ST_RST ##1 q.state == CSSC_ST_RUN);
	psave_round_c: cover property (q.state == CSSC_ST_SLEEP && q.mode == CSSC_M_PSAVE ##[1:20]
		cpu_resume);

endmodule : cssc_top
`default_nettype wire

// ==== tb/cssc_cpu_model.sv ====
// behavioural cpu core: issues the sleep instruction and raises wake interrupts
`timescale 1ns/100ps
`default_nettype none
module cssc_cpu_model (
	// clock
	input wire logic aclk,
	// bench commands: sleep request level, interrupt pulses {ext, async, adc, periph}
	input wire logic go_sleep,
	input wire logic [3:0] irq_sel,
	// block side
	input wire logic cpu_resume,
	output logic sleep_instr,
	output logic wake_ext_irq,
	output logic wake_async_irq,
	output logic wake_adc_irq,
	output logic wake_periph_irq
);
	logic go_q = 1'b0; // request level seen last cycle
	logic pulse_q = 1'b0; // instruction strobe
	logic [3:0] irq_q = 4'h0; // pending interrupts
	// one opcode per request edge, so a held request never sleeps twice
	always @(posedge aclk) begin
		go_q <= go_sleep;
		pulse_q <= go_sleep && !go_q; // single-cycle strobe
		if (cpu_resume) begin
			irq_q <= 4'h0; // handler entered, request served
		end else begin
			irq_q <= irq_q | irq_sel; // a level interrupt stays up until served
		end
	end
	assign sleep_instr = pulse_q;
	assign {wake_ext_irq, wake_async_irq, wake_adc_irq, wake_periph_irq} = irq_q;
endmodule : cssc_cpu_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the clock source and sleep control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ----------------------------------------------------------------
	// signals, named as the design ports
	// ----------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0;
	logic fuses_programmed = 1'b1, oscillator_option_fuse = 1'b0, adc_enabled = 1'b1;
	logic [3:0] clock_source_fuses = 4'h1;
	logic [1:0] startup_delay_fuses = 2'h0;
	logic [7:0] sig_row_hi_byte = 8'hA5; // factory trim seen by the block
	logic go_sleep = 1'b0;
	logic [3:0] irq_sel = 4'h0;
	// observed outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rc_nominal_sel;
	logic [31:0] s_axi_rdata;
	logic [7:0] sig_row_addr, rc_trim_value, rc_min_pct, rc_max_pct;
	logic [3:0] int_sense_ctl;
	logic sleep_instr, wake_ext_irq, wake_async_irq, wake_adc_irq, wake_periph_irq;
	logic cpu_resume, adc_autostart, rc_osc_en, ext_clk_sel, main_osc_en, wdt_osc_en;
	logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_asy_en;
	int miscompares = 0;
	int n_compared = 0;
	// start-up codes per fuse code, and cycles to cpu clock (delay plus one)
	logic [1:0] sut_tab [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h2};
	int dly_tab [5] = '{21, 1, 6, 1, 21};
	// ----------------------------------------------------------------
	// design and cpu partner; reset delays shortened to 5 and 20
	// ----------------------------------------------------------------
	cssc_top #(.RST_SHORT_CYC(5), .RST_LONG_CYC(20)) cssc_top_i (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .fuses_programmed, .clock_source_fuses,
		.startup_delay_fuses, .oscillator_option_fuse, .sig_row_addr, .sig_row_hi_byte,
		.sleep_instr, .adc_enabled, .wake_ext_irq, .wake_async_irq, .wake_adc_irq,
		.wake_periph_irq, .cpu_resume, .adc_autostart, .rc_osc_en, .rc_nominal_sel,
		.rc_trim_value, .rc_min_pct, .rc_max_pct, .ext_clk_sel, .main_osc_en, .wdt_osc_en,
		.clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .clk_asy_en, .int_sense_ctl
	);
	cssc_cpu_model cssc_cpu_model_i (
		.aclk, .go_sleep, .irq_sel, .cpu_resume, .sleep_instr, .wake_ext_irq,
		.wake_async_irq, .wake_adc_irq, .wake_periph_irq
	);
	// 100 MHz clock
	always #5 aclk = ~aclk;
	// watchdog: the whole run needs a few hundred cycles
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// aw and w offered together, each released when taken; bready held until bvalid
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axi_write(a, d, r);
		check(32'(r), 32'(er));
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		check(d, ed);
		check(32'(r), 32'(er));
	endtask : reg_read
	// reset with new fuses; returns edges after release until the cpu clock runs
	task automatic do_reset(input logic [3:0] c, input logic [1:0] s, input logic p, output int k);
		@(posedge aclk);
		aresetn <= 1'b0;
		clock_source_fuses <= c; // fuses and clock change only under reset
		startup_delay_fuses <= s;
		fuses_programmed <= p;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 1; k < 40; k++) begin
			@(posedge aclk);
			#1;
			if (clk_cpu_en === 1'b1) break;
		end
	endtask : do_reset
	// gates are {cpu, flash, io, adc, asy, osc}; wake 0 means no wake is sent
	task automatic sleep_cycle(input logic [2:0] m, input logic se, input logic [3:0] irq,
		input logic [5:0] gates, input logic astart, input int wake);
		int k;
		logic [5:0] g;
		// enable written just before the instruction
		reg_write(4'h0, {24'h0, m[2], se, m[1:0], 4'h0}, 2'h0);
		@(posedge aclk);
		go_sleep <= 1'b1;
		@(posedge aclk);
		go_sleep <= 1'b0;
		@(posedge aclk);
		#1;
		g = {clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_asy_en, main_osc_en};
		check(32'(g), 32'(gates));
		check(32'(adc_autostart), 32'(astart));
		if (wake > 0) begin
			@(posedge aclk);
			irq_sel <= irq;
			@(posedge aclk);
			irq_sel <= 4'h0;
			@(posedge aclk);
			for (k = 1; k < 16; k++) begin
				@(posedge aclk);
				#1;
				if (clk_cpu_en === 1'b1) break;
			end
			check(32'(k), 32'(wake));
			check(32'(cpu_resume), 32'h1);
			reg_write(4'h0, 32'h0, 2'h0);
		end
	endtask : sleep_cycle
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int k;
		// external clock and the four rc codes, each with a start-up setting
		for (int i = 0; i < 5; i++) begin
			do_reset(4'(i), sut_tab[i], 1'b1, k);
			check(32'(k), 32'(dly_tab[i]));
			check(32'(ext_clk_sel), 32'(i == 0));
			check(32'(rc_osc_en), 32'(i != 0));
			if (i > 0) check(32'(rc_nominal_sel), 32'(i - 1));
			check(32'(wdt_osc_en), 32'h1);
		end
		// blank fuse array falls back to 1 MHz rc with the long delay
		do_reset(4'h4, 2'h0, 1'b0, k);
		check(32'(k), 32'd21);
		check(32'(rc_nominal_sel), 32'h0);
		check(32'(sig_row_addr), 32'h0);
		reg_read(4'h4, 32'hA5, 2'h0);
		reg_read(4'h0, 32'h0, 2'h0);
		// trim end points and middle; no memory writes run meanwhile
		reg_write(4'h4, 32'h0, 2'h0);
		check(32'({rc_min_pct, rc_max_pct}), 32'h3264);
		reg_write(4'h4, 32'h7F, 2'h0);
		reg_read(4'h4, 32'h7F, 2'h0);
		check(32'(rc_max_pct > 8'h64 && rc_max_pct < 8'hC8), 32'h1);
		reg_write(4'h4, 32'hFF, 2'h0);
		check(32'({rc_min_pct, rc_max_pct}), 32'h64C8);
		check(32'(rc_trim_value), 32'hFF);
		// unmapped place, then the field layout of power control
		reg_read(4'hC, 32'h0, 2'h2);
		reg_write(4'hC, 32'hFF, 2'h2);
		reg_write(4'h0, 32'hB5, 2'h0);
		reg_read(4'h0, 32'hB5, 2'h0);
		check(32'(int_sense_ctl), 32'h5);
		// refused requests on the rc clock
		sleep_cycle(3'h2, 1'b0, 4'h8, 6'h3F, 1'b0, 0);
		sleep_cycle(3'h4, 1'b1, 4'h8, 6'h3F, 1'b0, 0);
		sleep_cycle(3'h5, 1'b1, 4'h8, 6'h3F, 1'b0, 0);
		sleep_cycle(3'h6, 1'b1, 4'h8, 6'h3F, 1'b0, 0);
		// the four modes open to the rc clock
		sleep_cycle(3'h0, 1'b1, 4'h1, 6'h0F, 1'b1, 4);
		sleep_cycle(3'h1, 1'b1, 4'h8, 6'h07, 1'b1, 4);
		sleep_cycle(3'h2, 1'b1, 4'h8, 6'h00, 1'b0, 10);
		sleep_cycle(3'h3, 1'b1, 4'h8, 6'h02, 1'b0, 10);
		@(posedge aclk);
		adc_enabled <= 1'b0;
		sleep_cycle(3'h0, 1'b1, 4'h8, 6'h0F, 1'b0, 4);
		// crystal source opens both standby modes
		do_reset(4'hA, 2'h0, 1'b1, k);
		check(32'(k), 32'd1);
		reg_read(4'h8, 32'h0A7D, 2'h0);
		sleep_cycle(3'h6, 1'b1, 4'h8, 6'h01, 1'b0, 4);
		sleep_cycle(3'h7, 1'b1, 4'h8, 6'h03, 1'b0, 4);
		// reset in the middle of power-down restarts the block
		sleep_cycle(3'h2, 1'b1, 4'h8, 6'h00, 1'b0, 0);
		do_reset(4'h1, 2'h1, 1'b1, k);
		check(32'(k), 32'd6);
		reg_read(4'h0, 32'h0, 2'h0);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
